// [design/dcs_pkg.sv]
// Shared constants, types and command decoding for the display command link
package dcs_pkg;
	// ---------------------------------------------------------------
	// Link and timing
	// ---------------------------------------------------------------
	localparam logic [6:0]  SLV_ADDR   = 7'h20;
	localparam int          CLK_HZ     = 40_000_000;
	localparam int          BAUD_RATE  = 9600;
	localparam int          BAUD_DIV   = CLK_HZ / BAUD_RATE;
	localparam int          SCL_HZ_DEF = 100_000;
	localparam logic [15:0] QTR_DEF    = 16'(CLK_HZ / (4 * SCL_HZ_DEF));
	localparam logic [3:0]  BIT_ACK    = 4'h8;
	localparam logic [3:0]  BIT_END    = 4'h9;
	localparam logic [3:0]  FRAME_BITS = 4'ha;
	localparam logic [2:0]  UART_LAST  = 3'h4;

	// ---------------------------------------------------------------
	// Command codes and display defaults
	// ---------------------------------------------------------------
	localparam logic [7:0]  C_INT = 8'h00;
	localparam logic [7:0]  A_INT = 8'h69;
	localparam logic [7:0]  C_HEX = 8'h01;
	localparam logic [7:0]  A_HEX = 8'h68;
	localparam logic [7:0]  C_BIN = 8'h02;
	localparam logic [7:0]  A_BIN = 8'h62;
	localparam logic [7:0]  C_FLT = 8'h03;
	localparam logic [7:0]  A_FLT = 8'h66;
	localparam logic [7:0]  C_POS = 8'h04;
	localparam logic [7:0]  A_POS = 8'h70;
	localparam logic [7:0]  C_SCL = 8'h05;
	localparam logic [7:0]  A_SCL = 8'h73;
	localparam logic [7:0]  C_DEF = 8'h06;
	localparam logic [7:0]  A_DEF = 8'h64;
	localparam logic [2:0]  LEN_SHORT  = 3'h2;
	localparam logic [2:0]  LEN_LONG   = 3'h4;
	localparam logic [31:0] SCALE_DEF  = 32'h391d4952;
	localparam logic [15:0] DIGITS_DEF = 16'h0005;
	localparam logic [7:0]  FP_BIAS    = 8'h7f;
	localparam logic [7:0]  FP_EXP_MAX = 8'hff;
	localparam int          SW_TOP_BIT = 0;
	localparam int          SW_SEC_BIT = 1;

	// ---------------------------------------------------------------
	// Controller register map
	// ---------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL  = 8'h00;
	localparam logic [7:0]  REG_DATA  = 8'h04;
	localparam logic [7:0]  REG_STAT  = 8'h08;
	localparam logic [7:0]  REG_QTR   = 8'h0c;
	localparam int          CTRL_GO_W = 8;
	localparam int          CTRL_GO_R = 9;

	typedef enum logic [2:0] {OP_INT, OP_HEX, OP_BIN, OP_FLT, OP_POS, OP_SCL, OP_DEF,
		OP_BAD} dcs_op_t;
	typedef enum logic [2:0] {MODE_DEC, MODE_HEX, MODE_BIN, MODE_FLT, MODE_POS} dcs_mode_t;

	function automatic dcs_op_t dcs_decode(input logic [7:0] b);
		if (b == C_INT || b == A_INT) return OP_INT;
		else if (b == C_HEX || b == A_HEX) return OP_HEX;
		else if (b == C_BIN || b == A_BIN) return OP_BIN;
		else if (b == C_FLT || b == A_FLT) return OP_FLT;
		else if (b == C_POS || b == A_POS) return OP_POS;
		else if (b == C_SCL || b == A_SCL) return OP_SCL;
		else if (b == C_DEF || b == A_DEF) return OP_DEF;
		return OP_BAD;
	endfunction : dcs_decode

	function automatic logic [2:0] dcs_plen(input dcs_op_t op);
		case (op)
			OP_INT, OP_HEX, OP_BIN, OP_DEF: return LEN_SHORT;
			OP_FLT, OP_POS, OP_SCL:         return LEN_LONG;
			default:                        return 3'h0;
		endcase
	endfunction : dcs_plen
endpackage : dcs_pkg

// [design/dcs_bus_if.sv]
// Two-wire open-drain bus joining the display slave and its controller
`timescale 1ns/10ps
interface dcs_bus_if;
	logic scl;
	logic sda;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;

	// Pull-up: the wire is low only while someone drives a low
	assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

	modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
		output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface : dcs_bus_if

// [design/dcs_dev.sv]
// Display command slave: two-wire slave, command interpreter, status UART
//
// Behaviour
// - Slave answers at fixed address 0x20.
// - Write transfers carry command and payload bytes.
// - Master writes before every read transfer.
// - No sub-addressing; bytes are command stream.
// - 0x00/'i': two bytes, shown decimal.
// - 0x01/'h': two bytes, shown hexadecimal.
// - 0x02/'b': two bytes, shown binary.
// - 0x03/'f': four bytes, single float.
// - 0x04/'p': four bytes, signed position count.
// - 0x05/'s': four bytes stored as scale.
// - 0x06/'d': defaults, two-byte significant digits.
// - Float value displayed without any scaling.
// - Position shown as count times scale.
// - Scale is 0.00015 until set.
// - One read: one switch status byte.
// - Bit 0 high while top switch released.
// - Bit 1 high while second switch released.
// - UART sends state only, 9600 8N1.
// - Bus works at 50 to 400 kHz.
`timescale 1ns/10ps
module dcs_dev
	import dcs_pkg::*;
#(
	parameter int BAUD_DIV_P = BAUD_DIV
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	dcs_bus_if.dev           bus,
	input  wire logic        sw_top_n_i,
	input  wire logic        sw_sec_n_i,
	output dcs_mode_t        mode_o,
	output logic [31:0]      value_o,
	output logic [15:0]      digits_o,
	output logic [31:0]      scale_o,
	output logic             upd_o,
	output logic             uart_tx_o
);
	typedef enum logic [1:0] {D_IDLE, D_RX, D_TX} dcs_dst_t;

	// ---------------------------------------------------------------
	// Float helpers (truncating, no denormals)
	// ---------------------------------------------------------------
	function automatic logic [31:0] fp_from_int(input logic [31:0] v);
		logic        s;
		logic [31:0] a;
		logic [31:0] n;
		logic [4:0]  msb;
		s   = v[31];
		a   = s ? (~v + 32'h1) : v;
		msb = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (a[i]) msb = 5'(i);
		end
		n = a << (5'd31 - msb);
		if (a == 32'h0) return 32'h0;
		return {s, FP_BIAS + {3'h0, msb}, n[30:8]};
	endfunction : fp_from_int

	function automatic logic [31:0] fp_mul(input logic [31:0] a, input logic [31:0] b);
		logic        s;
		logic [47:0] p;
		logic [9:0]  e;
		logic [22:0] m;
		s = a[31] ^ b[31];
		p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - {2'h0, FP_BIAS} + {9'h000, p[47]};
		m = p[47] ? p[46:24] : p[45:23];
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9] || e == 10'h000) begin
			return {s, 31'h0};
		end
		if (e >= {2'h0, FP_EXP_MAX}) return {s, FP_EXP_MAX, 23'h0};
		return {s, e[7:0], m};
	endfunction : fp_mul

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0]  scl_r;
	logic [2:0]  sda_r;
	logic [1:0]  swt_r;
	logic [1:0]  sws_r;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scl_r <= 3'h7;
			sda_r <= 3'h7;
			swt_r <= 2'h3;
			sws_r <= 2'h3;
		end else begin
			scl_r <= {scl_r[1:0], bus.scl};
			sda_r <= {sda_r[1:0], bus.sda};
			swt_r <= {swt_r[0], sw_top_n_i};
			sws_r <= {sws_r[0], sw_sec_n_i};
		end
	end

	wire        scl_s   = scl_r[1];
	wire        scl_p   = scl_r[2];
	wire        sda_s   = sda_r[1];
	wire        sda_p   = sda_r[2];
	wire        start_w = scl_s & scl_p & sda_p & ~sda_s;
	wire        stop_w  = scl_s & scl_p & ~sda_p & sda_s;
	wire        rise_w  = scl_s & ~scl_p;
	wire        fall_w  = ~scl_s & scl_p;
	wire [7:0]  stat_w  = 8'(({7'h00, swt_r[1]} << SW_TOP_BIT) |
		({7'h00, sws_r[1]} << SW_SEC_BIT));

	// ---------------------------------------------------------------
	// Bit engine
	// ---------------------------------------------------------------
	dcs_dst_t    st_q;
	logic [3:0]  bit_q;
	logic [7:0]  sh_q;
	logic [7:0]  tx_q;
	logic        oe_q;
	logic        addr_q;
	logic        rd_q;

	wire         hit_w  = sh_q[7:1] == SLV_ADDR;
	wire         data_w = (st_q == D_RX) && !addr_q && fall_w && bit_q == BIT_ACK;

	assign bus.dev_scl_o  = 1'b0;
	assign bus.dev_scl_oe = 1'b0;
	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_sda_oe = oe_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_q   <= D_IDLE;
			bit_q  <= 4'h0;
			sh_q   <= 8'h00;
			tx_q   <= 8'h00;
			oe_q   <= 1'b0;
			addr_q <= 1'b0;
			rd_q   <= 1'b0;
		end else if (start_w) begin
			st_q   <= D_RX;
			addr_q <= 1'b1;
			bit_q  <= 4'h0;
			oe_q   <= 1'b0;
		end else if (stop_w) begin
			st_q <= D_IDLE;
			oe_q <= 1'b0;
		end else begin
			case (st_q)
				D_RX: begin
					if (rise_w && bit_q < BIT_ACK) begin
						sh_q  <= {sh_q[6:0], sda_s};
						bit_q <= bit_q + 4'h1;
					end else if (fall_w && bit_q == BIT_ACK) begin
						bit_q <= BIT_END;
						if (!addr_q) begin
							oe_q <= 1'b1;
						end else if (hit_w) begin
							oe_q <= 1'b1;
							rd_q <= sh_q[0];
						end else begin
							st_q <= D_IDLE;
						end
					end else if (fall_w && bit_q == BIT_END) begin
						bit_q  <= 4'h0;
						addr_q <= 1'b0;
						if (addr_q && rd_q) begin
							st_q <= D_TX;
							tx_q <= stat_w;
							oe_q <= ~stat_w[7];
						end else begin
							oe_q <= 1'b0;
						end
					end
				end
				D_TX: begin
					if (rise_w && bit_q < BIT_ACK) begin
						bit_q <= bit_q + 4'h1;
					end else if (fall_w && bit_q < BIT_ACK) begin
						oe_q <= ~tx_q[6];
						tx_q <= {tx_q[6:0], 1'b0};
					end else if (fall_w) begin
						// Single byte only; further reads see a released line
						oe_q <= 1'b0;
						st_q <= D_IDLE;
					end
				end
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Command parser
	// ---------------------------------------------------------------
	dcs_op_t     op_q;
	logic [2:0]  need_q;
	logic        bad_q;
	logic        go_q;
	logic [31:0] pay_q;

	wire dcs_op_t op_w = dcs_decode(sh_q);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			op_q   <= OP_BAD;
			need_q <= 3'h0;
			bad_q  <= 1'b0;
			go_q   <= 1'b0;
			pay_q  <= 32'h0;
		end else begin
			go_q <= 1'b0;
			if (start_w || stop_w) begin
				need_q <= 3'h0;
				bad_q  <= 1'b0;
			end else if (data_w && !bad_q) begin
				if (need_q == 3'h0) begin
					op_q   <= op_w;
					bad_q  <= op_w == OP_BAD;
					need_q <= dcs_plen(op_w);
				end else begin
					pay_q  <= {sh_q, pay_q[31:8]};
					need_q <= need_q - 3'h1;
					go_q   <= need_q == 3'h1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Display state
	// ---------------------------------------------------------------
	wire [31:0] pos_w = fp_mul(fp_from_int(pay_q), scale_o);
	wire [15:0] half_w = pay_q[31:16];

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mode_o   <= MODE_DEC;
			value_o  <= 32'h0;
			digits_o <= DIGITS_DEF;
			scale_o  <= SCALE_DEF;
			upd_o    <= 1'b0;
		end else begin
			upd_o <= go_q && op_q != OP_SCL;
			if (go_q) begin
				case (op_q)
					OP_INT: begin
						mode_o  <= MODE_DEC;
						value_o <= {{16{half_w[15]}}, half_w};
					end
					OP_HEX: begin
						mode_o  <= MODE_HEX;
						value_o <= {16'h0000, half_w};
					end
					OP_BIN: begin
						mode_o  <= MODE_BIN;
						value_o <= {16'h0000, half_w};
					end
					OP_FLT: begin
						mode_o  <= MODE_FLT;
						value_o <= pay_q;
					end
					OP_POS: begin
						mode_o  <= MODE_POS;
						value_o <= pos_w;
					end
					OP_SCL: scale_o <= pay_q;
					OP_DEF: begin
						mode_o   <= MODE_DEC;
						value_o  <= 32'h0;
						scale_o  <= SCALE_DEF;
						digits_o <= half_w;
					end
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Status UART: mode byte then value, LSB first, after each update
	// ---------------------------------------------------------------
	logic        tb_q;
	logic        pend_q;
	logic [15:0] div_q;
	logic [3:0]  tbit_q;
	logic [2:0]  tbyte_q;
	logic [9:0]  tsh_q;
	logic [39:0] snap_q;

	wire tick_w = div_q == 16'h0000;
	wire load_w = !tb_q && pend_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tb_q      <= 1'b0;
			pend_q    <= 1'b0;
			div_q     <= 16'h0000;
			tbit_q    <= 4'h0;
			tbyte_q   <= 3'h0;
			tsh_q     <= 10'h3ff;
			snap_q    <= 40'h0;
			uart_tx_o <= 1'b1;
		end else begin
			pend_q <= upd_o | (pend_q & ~load_w);
			if (load_w) begin
				tb_q    <= 1'b1;
				snap_q  <= {value_o, 5'h00, mode_o};
				tsh_q   <= {1'b1, 5'h00, mode_o, 1'b0};
				tbit_q  <= 4'h0;
				tbyte_q <= 3'h0;
				div_q   <= 16'h0000;
			end else if (tb_q) begin
				div_q <= (div_q == 16'(BAUD_DIV_P - 1)) ? 16'h0000 : div_q + 16'h0001;
				if (tick_w && tbit_q == FRAME_BITS) begin
					// One idle bit time between bytes keeps the loader simple
					if (tbyte_q == UART_LAST) begin
						tb_q <= 1'b0;
					end else begin
						tbyte_q <= tbyte_q + 3'h1;
						tsh_q   <= {1'b1, snap_q[15:8], 1'b0};
						snap_q  <= {8'h00, snap_q[39:8]};
						tbit_q  <= 4'h0;
					end
				end else if (tick_w) begin
					uart_tx_o <= tsh_q[0];
					tsh_q     <= {1'b1, tsh_q[9:1]};
					tbit_q    <= tbit_q + 4'h1;
				end
			end
		end
	end
endmodule : dcs_dev

// [design/dcs_host.sv]
// Two-wire controller for the display slave, driven from Wishbone registers
`timescale 1ns/10ps
module dcs_host
	import dcs_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	dcs_bus_if.host          bus
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} dcs_hst_t;

	// ---------------------------------------------------------------
	// Register slave
	// ---------------------------------------------------------------
	logic [7:0]  cmd_q;
	logic [31:0] pay_q;
	logic [15:0] qtr_q;
	logic        busy_q;
	logic        nack_q;
	logic [7:0]  rdb_q;

	wire         req_w  = wb_cyc_i & wb_stb_i;
	wire         wr_w   = req_w & wb_we_i & wb_ack_o;
	wire         h_ctrl = wb_adr_i == REG_CTRL;
	wire         h_data = wb_adr_i == REG_DATA;
	wire         h_stat = wb_adr_i == REG_STAT;
	wire         h_qtr  = wb_adr_i == REG_QTR;
	wire [31:0]  mask_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
		{8{wb_sel_i[0]}}};
	wire [31:0]  rdat_w = h_ctrl ? {24'h0, cmd_q} :
		h_data ? pay_q :
		h_stat ? {16'h0, rdb_q, 6'h00, nack_q, busy_q} :
		h_qtr ? {16'h0, qtr_q} : 32'h0;
	wire [7:0]   ncmd_w = wb_sel_i[0] ? wb_dat_i[7:0] : cmd_q;
	wire         gow_w  = wr_w & h_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_GO_W] & ~busy_q;
	wire         gor_w  = wr_w & h_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_GO_R] & ~busy_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			cmd_q    <= 8'h00;
			pay_q    <= 32'h0;
			qtr_q    <= QTR_DEF;
		end else begin
			wb_ack_o <= req_w & ~wb_ack_o;
			if (req_w && !wb_ack_o) wb_dat_o <= rdat_w;
			if (wr_w && h_ctrl) cmd_q <= ncmd_w;
			if (wr_w && h_data) pay_q <= (pay_q & ~mask_w) | (wb_dat_i & mask_w);
			if (wr_w && h_qtr) qtr_q <= (qtr_q & ~mask_w[15:0]) | (wb_dat_i[15:0] & mask_w[15:0]);
		end
	end

	// ---------------------------------------------------------------
	// Bit sequencer: four quarter phases per bus bit
	// ---------------------------------------------------------------
	dcs_hst_t    st_q;
	logic [1:0]  ph_q;
	logic [15:0] qc_q;
	logic [3:0]  bit_q;
	logic [2:0]  idx_q;
	logic [2:0]  last_q;
	logic [7:0]  sh_q;
	logic [31:0] psh_q;
	logic        rdop_q;
	logic        sec_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic [1:0]  sda_r;

	wire         tick_w = (st_q != H_IDLE) && qc_q == qtr_q;
	wire         rxb_w  = rdop_q & sec_q & (idx_q != 3'h0);
	wire         ack_w  = bit_q == BIT_ACK;

	assign bus.host_scl_o  = 1'b0;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_oe = sda_oe_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_q     <= H_IDLE;
			ph_q     <= 2'h0;
			qc_q     <= 16'h0000;
			bit_q    <= 4'h0;
			idx_q    <= 3'h0;
			last_q   <= 3'h0;
			sh_q     <= 8'h00;
			psh_q    <= 32'h0;
			rdop_q   <= 1'b0;
			sec_q    <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			sda_r    <= 2'h3;
			busy_q   <= 1'b0;
			nack_q   <= 1'b0;
			rdb_q    <= 8'h00;
		end else begin
			sda_r <= {sda_r[0], bus.sda};
			qc_q  <= (tick_w || st_q == H_IDLE) ? 16'h0000 : qc_q + 16'h0001;
			if (tick_w) ph_q <= ph_q + 2'h1;
			case (st_q)
				H_IDLE: begin
					ph_q <= 2'h0;
					if (gow_w || gor_w) begin
						busy_q <= 1'b1;
						nack_q <= 1'b0;
						rdop_q <= gor_w;
						sec_q  <= 1'b0;
						psh_q  <= pay_q;
						st_q   <= H_START;
						// A read first sends an empty write to select the switch byte
						last_q <= gor_w ? 3'h0 : 3'h1 + dcs_plen(dcs_decode(ncmd_w));
					end
				end
				H_START: if (tick_w) begin
					case (ph_q)
						2'h0: begin
							scl_oe_q <= 1'b0;
							sda_oe_q <= 1'b0;
						end
						2'h1: sda_oe_q <= 1'b1;
						2'h2: begin
							scl_oe_q <= 1'b1;
							st_q     <= H_BIT;
							ph_q     <= 2'h0;
							bit_q    <= 4'h0;
							idx_q    <= 3'h0;
							sh_q     <= {SLV_ADDR, sec_q};
						end
						default: ;
					endcase
				end
				H_BIT: if (tick_w) begin
					case (ph_q)
						2'h0: sda_oe_q <= ~ack_w & ~rxb_w & ~sh_q[7];
						2'h1: scl_oe_q <= 1'b0;
						2'h2: begin
							if (ack_w && !rxb_w && sda_r[1]) nack_q <= 1'b1;
							if (!ack_w && rxb_w) rdb_q <= {rdb_q[6:0], sda_r[1]};
						end
						default: begin
							scl_oe_q <= 1'b1;
							if (!ack_w) begin
								bit_q <= bit_q + 4'h1;
								sh_q  <= {sh_q[6:0], 1'b0};
							end else if (nack_q || idx_q == last_q) begin
								st_q <= H_STOP;
							end else begin
								bit_q <= 4'h0;
								idx_q <= idx_q + 3'h1;
								sh_q  <= (idx_q == 3'h0) ? cmd_q : psh_q[7:0];
								if (idx_q != 3'h0) psh_q <= {8'h00, psh_q[31:8]};
							end
						end
					endcase
				end
				default: if (tick_w) begin
					case (ph_q)
						2'h0: sda_oe_q <= 1'b1;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b0;
						default: begin
							if (rdop_q && !sec_q && !nack_q) begin
								sec_q  <= 1'b1;
								last_q <= 3'h1;
								st_q   <= H_START;
							end else begin
								busy_q <= 1'b0;
								st_q   <= H_IDLE;
							end
						end
					endcase
				end
			endcase
		end
	end
endmodule : dcs_host

// [test/dcs_props.sv]
// Wire-level checks on the two-wire link between controller and slave
`timescale 1ns/10ps
module dcs_props
	import dcs_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic dev_scl_oe,
	input  wire logic dev_sda_oe,
	input  wire logic host_scl_oe,
	input  wire logic host_sda_oe
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_q;
	logic [1:0] byte_q;
	logic [7:0] sh_q;
	logic       rd_q;
	wire        start = scl & scl_q & sda_q & ~sda;
	wire        rise  = scl & ~scl_q;
	wire        slot  = rise && bit_q == 4'h8;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// Bit and byte tracking, restarted by every START
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			{scl_q, sda_q, bit_q, byte_q, sh_q, rd_q} <= {2'b11, 4'h0, 2'h0, 8'h00, 1'b0};
		end else begin
			{scl_q, sda_q} <= {scl, sda};
			if (start) begin
				{bit_q, byte_q} <= {4'h0, 2'h0};
			end else if (rise && bit_q == 4'h8) begin
				bit_q  <= 4'h0;
				byte_q <= byte_q + 2'(byte_q != 2'h3);
				if (byte_q == 2'h0) rd_q <= sh_q[0];
			end else if (rise) begin
				sh_q  <= {sh_q[6:0], sda};
				bit_q <= bit_q + 4'h1;
			end
		end
	end

	sequence start_s; scl && $fell(sda); endsequence
	sequence stop_s; scl && $rose(sda); endsequence
	sequence ack_s; $rose(dev_sda_oe); endsequence

	no_stretch_a: assert property (rise |-> !dev_scl_oe && $stable(dev_sda_oe))
		else $error("slave drove the clock or moved data at a clock rise");
	start_free_a: assert property (start_s |-> !dev_sda_oe)
		else $error("slave held data low at START");
	addr_quiet_a: assert property (byte_q == 2'h0 && bit_q != 4'h8 |-> !dev_sda_oe)
		else $error("slave drove data during address bits");
	addr_ack_a: assert property (slot && byte_q == 2'h0 |-> sda == (sh_q[7:1] != SLV_ADDR))
		else $error("address acknowledge wrong");
	wr_ack_a: assert property (slot && byte_q != 2'h0 && !rd_q |-> !sda && dev_sda_oe)
		else $error("written byte not acknowledged");
	rd_nack_a: assert property (slot && byte_q == 2'h1 && rd_q |-> sda && !dev_sda_oe)
		else $error("slave held data in the read acknowledge slot");
	low_change_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("slave changed data while clock high");
	ack_hold_a: assert property (ack_s |=> dev_sda_oe [*8])
		else $error("slave low pulse too short");
	stop_free_a: assert property (stop_s |=> !dev_sda_oe [*8])
		else $error("slave drove data right after STOP");
	rst_idle_a: assert property ($fell(rst_i) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe)
		else $error("bus not idle after reset");
endmodule : dcs_props

// [test/test_i2c_display_command_slave.sv]
// Bench joining controller and display slave, driven over Wishbone
`timescale 1ns/10ps
module test_i2c_display_command_slave import dcs_pkg::*;;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic [3:0]  wb_sel = 4'h0;
	logic        wb_we = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic [31:0] wb_q;
	logic        wb_ack;
	logic        sw_top_n = 1'b1;
	logic        sw_sec_n = 1'b1;
	dcs_mode_t   mode;
	logic [31:0] value, scale, rd;
	logic [15:0] digits;
	logic        upd, uart_tx;
	logic [2:0]  exp_mode = MODE_DEC;
	logic [31:0] exp_val = 32'h0, exp_scl = SCALE_DEF, pos_exp = 32'h0, lfsr = 32'h0000000d;
	logic [15:0] exp_dig = DIGITS_DEF;
	logic [7:0]  codes [12] = '{C_INT, A_INT, C_HEX, A_HEX, C_BIN, A_BIN, C_FLT, A_FLT,
		C_SCL, A_SCL, C_DEF, A_DEF};
	int          fail_count = 0, check_count = 0, upd_cnt = 0, exp_upd = 0;

	dcs_bus_if bus_if ();
	dcs_dev #(.BAUD_DIV_P(8)) i_dcs_dev (.clock_i(clock_i), .rst_i(rst_i), .bus(bus_if),
		.sw_top_n_i(sw_top_n), .sw_sec_n_i(sw_sec_n), .mode_o(mode), .value_o(value),
		.digits_o(digits), .scale_o(scale), .upd_o(upd), .uart_tx_o(uart_tx));
	dcs_host i_dcs_host (.clock_i(clock_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_q), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .bus(bus_if));
	dcs_props i_dcs_props (.clock_i(clock_i), .rst_i(rst_i), .scl(bus_if.scl), .sda(bus_if.sda),
		.dev_scl_oe(bus_if.dev_scl_oe), .dev_sda_oe(bus_if.dev_sda_oe),
		.host_scl_oe(bus_if.host_scl_oe), .host_sda_oe(bus_if.host_sda_oe));

	initial forever #12.5 clock_i = ~clock_i;
	always @(posedge clock_i) if (upd === 1'b1) upd_cnt <= upd_cnt + 1;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
		check_count++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask : chk

	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out

	// Request held until ack is sampled, then released for one cycle at least
	task automatic wb_io(input logic [7:0] a, input logic we, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clock_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, we, a, d, s};
		do @(posedge clock_i); while (wb_ack !== 1'b1);
		rd = wb_q;
		{wb_cyc, wb_stb} <= 2'b00;
	endtask : wb_io

	task automatic wait_idle();
		do wb_io(REG_STAT, 1'b0, 32'h0, 4'hf); while (rd[0] !== 1'b0);
	endtask : wait_idle

	task automatic model(input logic [7:0] c, input logic [31:0] p);
		case (c)
			C_INT, A_INT: {exp_mode, exp_val} = {MODE_DEC, {16{p[15]}}, p[15:0]};
			C_HEX, A_HEX: {exp_mode, exp_val} = {MODE_HEX, 16'h0, p[15:0]};
			C_BIN, A_BIN: {exp_mode, exp_val} = {MODE_BIN, 16'h0, p[15:0]};
			C_FLT, A_FLT: {exp_mode, exp_val} = {MODE_FLT, p};
			C_POS, A_POS: {exp_mode, exp_val} = {MODE_POS, pos_exp};
			C_SCL, A_SCL: exp_scl = p;
			C_DEF, A_DEF: begin
				{exp_mode, exp_val} = {MODE_DEC, 32'h0};
				{exp_dig, exp_scl} = {p[15:0], SCALE_DEF};
			end
			default: ;
		endcase
		if (!(c inside {C_SCL, A_SCL}) && (c <= C_DEF || c inside {A_INT, A_HEX, A_BIN, A_FLT,
			A_POS, A_DEF})) exp_upd += 1;
	endtask : model

	task automatic run_cmd(input logic [7:0] c, input logic [31:0] p);
		wb_io(REG_DATA, 1'b1, p, 4'hf);
		model(c, p);
		wb_io(REG_CTRL, 1'b1, (32'h1 << CTRL_GO_W) | {24'h0, c}, 4'h3);
		wait_idle();
		chk({29'h0, mode}, {29'h0, exp_mode}, "mode");
		chk(value, exp_val, "value");
		chk({16'h0, digits}, {16'h0, exp_dig}, "digits");
		chk(scale, exp_scl, "scale");
		chk(32'(upd_cnt), 32'(exp_upd), "updates");
	endtask : run_cmd

	task automatic uart_rx(output logic [7:0] b);
		int n;
		n = 0;
		while (uart_tx !== 1'b0 && n < 400) begin
			n++;
			@(posedge clock_i);
		end
		repeat (4) @(posedge clock_i);
		chk({31'h0, uart_tx}, 32'h0, "start bit");
		for (int k = 0; k < 8; k++) begin
			repeat (8) @(posedge clock_i);
			b[k] = uart_tx;
		end
		repeat (8) @(posedge clock_i);
		chk({31'h0, uart_tx}, 32'h1, "stop bit");
	endtask : uart_rx

	// First two frames after each update: mode, then low value byte
	always begin : uart_mon
		logic [7:0] b;
		logic [7:0] want_v;
		logic [2:0] want_m;
		@(posedge clock_i iff upd === 1'b1);
		// Latched now: the next command rewrites the model before frame two ends
		want_m = exp_mode;
		want_v = exp_val[7:0];
		uart_rx(b);
		chk({24'h0, b}, {29'h0, want_m}, "tx mode");
		uart_rx(b);
		chk({24'h0, b}, {24'h0, want_v}, "tx value");
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		chk({29'h0, mode}, {29'h0, MODE_DEC}, "reset mode");
		chk(scale, SCALE_DEF, "reset scale");
		chk({16'h0, digits}, {16'h0, DIGITS_DEF}, "reset digits");
		chk({31'h0, uart_tx}, 32'h1, "tx idle");
		wb_io(REG_QTR, 1'b0, 32'h0, 4'hf);
		chk(rd, {16'h0, QTR_DEF}, "qtr reset");
		wb_io(REG_QTR, 1'b1, 32'h0000ff08, 4'h1);
		wb_io(8'h10, 1'b1, 32'h5a5a5a5a, 4'hf);
		wb_io(8'h10, 1'b0, 32'h0, 4'hf);
		chk(rd, 32'h0, "unmapped");
		wb_io(REG_QTR, 1'b0, 32'h0, 4'hf);
		chk(rd, 32'h00000008, "qtr lane");
		run_cmd(C_INT, 32'hffff8000);
		for (int i = 0; i < 12; i++) begin
			repeat (8) lfsr = lfsr_next(lfsr);
			run_cmd(codes[i], lfsr);
		end
		run_cmd(8'h07, lfsr);
		run_cmd(8'hff, lfsr);
		run_cmd(A_SCL, 32'h3f800000);
		pos_exp = 32'h40400000;
		run_cmd(C_POS, 32'h00000003);
		run_cmd(C_SCL, 32'h3f000000);
		pos_exp = 32'hbf800000;
		run_cmd(A_POS, 32'hfffffffe);
		for (int i = 0; i < 4; i++) begin
			{sw_sec_n, sw_top_n} <= i[1:0];
			repeat (4) @(posedge clock_i);
			wb_io(REG_CTRL, 1'b1, 32'h1 << CTRL_GO_R, 4'h2);
			wait_idle();
			chk({24'h0, rd[15:8]}, {30'h0, i[1:0]}, "switches");
			chk({31'h0, rd[1]}, 32'h0, "read nack");
		end
		close_out();
	end

	initial begin
		repeat (90000) @(posedge clock_i);
		fail_count++;
		close_out();
	end
endmodule : test_i2c_display_command_slave
